// ### hdl/fsf_bank.sv
// Supply, clock and integrity fault flag bank with status summary bits.
// Assumes monitor levels from other domains; register strobes and enables on clk.
`include "fsf_params.svh"
`default_nettype none

module fsf_bank
    import fsf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,

    // Register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd_en,
    output logic [15:0]      reg_rd_data,
    output logic             reg_rd_valid,

    // Supply monitors, high when healthy
    input  wire logic        ana_overvolt_ok,
    input  wire logic        ana_undervolt_ok,
    input  wire logic        io_overvolt_ok,
    input  wire logic        io_undervolt_ok,
    input  wire logic        core_overvolt_ok,
    input  wire logic        core_undervolt_ok,
    input  wire logic        ana_oscillation_ok,
    input  wire logic        io_oscillation_ok,
    input  wire logic        core_oscillation_ok,
    input  wire logic        ana_overtemp_ok,
    input  wire logic        io_overtemp_ok,
    input  wire logic        ana_current_limit_ok,
    input  wire logic        io_current_limit_ok,
    input  wire logic        ground_a_connected,
    input  wire logic        ground_b_connected,
    input  wire logic        core_ground_connected,

    // Clock monitors, high when healthy
    input  wire logic        clock_freq_ok,
    input  wire logic        diag_osc_watchdog_ok,
    input  wire logic        main_clock_watchdog_ok,

    // Integrity checkers, high when healthy
    input  wire logic        cfg_section1_crc_ok,
    input  wire logic        cfg_section2_crc_ok,
    input  wire logic        cfg_section3_crc_ok,
    input  wire logic        memory_crc_ok,

    // Bank selection, on clk, valid from reset release
    input  wire logic        otp_primary_sel,

    // Summary enables, 1 counts the flag
    input  wire logic [2:0]  clock_fault_en,
    input  wire logic [3:0]  digital_fault_en,

    // Summary outputs, active low faults
    output logic             clock_summary_ok,
    output logic             integrity_summary_ok
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    function automatic fsf_word_t clear_mask(input logic       wr,
                                             input logic [7:0] addr,
                                             input logic [7:0] target,
                                             input fsf_word_t  data);
        clear_mask = (wr && addr_hit(addr, target)) ? data : 16'h0000;
    endfunction : clear_mask

    ////////////////////////////////////////////////////////////////////////////
    // State

    fsf_bank_state_t st;
    fsf_bank_state_t next_st;

    fsf_flag_if sup_if ();
    fsf_flag_if clk_if ();
    fsf_flag_if dig_if ();

    fsf_word_t   sup_raw;
    logic [2:0]  clk_raw;
    logic [3:0]  dig_raw;
    fsf_word_t   dig_view;
    logic [2:0]  clk_flags;
    logic [3:0]  dig_flags;
    logic        clk_any;
    logic        dig_any;
    logic        sum_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Monitor levels gathered in register bit order

    assign sup_raw = {
        ana_overvolt_ok,
        ana_undervolt_ok,
        io_overvolt_ok,
        io_undervolt_ok,
        core_overvolt_ok,
        core_undervolt_ok,
        ana_oscillation_ok,
        io_oscillation_ok,
        core_oscillation_ok,
        ana_overtemp_ok,
        io_overtemp_ok,
        ana_current_limit_ok,
        io_current_limit_ok,
        ground_a_connected,
        ground_b_connected,
        core_ground_connected
    };

    assign clk_raw = {
        clock_freq_ok,
        diag_osc_watchdog_ok,
        main_clock_watchdog_ok
    };

    assign dig_raw = {
        cfg_section1_crc_ok,
        cfg_section2_crc_ok,
        cfg_section3_crc_ok,
        memory_crc_ok
    };

    ////////////////////////////////////////////////////////////////////////////
    // Flag registers

    assign sup_if.fault_n = st.sup_sync;
    assign sup_if.clr     = clear_mask(reg_wr_en, reg_addr, `FSF_ADDR_SUPPLY, reg_wdata);

    assign clk_if.fault_n = {13'h1FFF, st.clk_sync};
    assign clk_if.clr     = clear_mask(reg_wr_en, reg_addr, `FSF_ADDR_CLOCK, reg_wdata);

    assign dig_if.fault_n = {st.dig_sync[3:1], 1'b1, st.dig_sync[0], 11'h7FF};
    assign dig_if.clr     = clear_mask(reg_wr_en, reg_addr, `FSF_ADDR_DIGITAL, reg_wdata);

    fsf_flag_reg #(
        .RST   (`FSF_SUPPLY_RST),
        .WMASK (`FSF_SUPPLY_WMASK),
        .FIXED (`FSF_SUPPLY_FIXED)
    ) u_supply (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (sup_if.store)
    );

    fsf_flag_reg #(
        .RST   (`FSF_CLOCK_RST),
        .WMASK (`FSF_CLOCK_WMASK),
        .FIXED (`FSF_CLOCK_FIXED)
    ) u_clock (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (clk_if.store)
    );

    fsf_flag_reg #(
        .RST   (`FSF_DIGITAL_RST & `FSF_DIGITAL_WMASK),
        .WMASK (`FSF_DIGITAL_WMASK),
        .FIXED (`FSF_DIGITAL_FIXED)
    ) u_digital (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (dig_if.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register view of the integrity word with the bank bit merged in

    always_comb begin
        dig_view                = dig_if.flags;
        dig_view[`FSF_BIT_BANK] = st.bank_primary;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary terms

    assign clk_flags = clk_if.flags[2:0];
    assign dig_flags = {dig_if.flags[`FSF_DIG_CRC1],
                        dig_if.flags[`FSF_DIG_CRC2],
                        dig_if.flags[`FSF_DIG_CRC3],
                        dig_if.flags[`FSF_DIG_MEM]};

    assign clk_any = |(~clk_flags & clock_fault_en);
    assign dig_any = |(~dig_flags & digital_fault_en);
    assign sum_wr  = reg_wr_en && addr_hit(reg_addr, `FSF_ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;

        // Two-stage synchronisers
        next_st.sup_meta = sup_raw;
        next_st.sup_sync = st.sup_meta;
        next_st.clk_meta = clk_raw;
        next_st.clk_sync = st.clk_meta;
        next_st.dig_meta = dig_raw;
        next_st.dig_sync = st.dig_meta;

        // Bank choice caught once after reset release
        if (!st.bank_taken) begin
            next_st.bank_primary = otp_primary_sel;
            next_st.bank_taken   = 1'b1;
        end

        // Sticky summaries, a pending fault wins over the restore
        if (sum_wr && reg_wdata[`FSF_BIT_SUM_CLOCK]) begin
            next_st.clk_sum = 1'b1;
        end
        if (clk_any) begin
            next_st.clk_sum = 1'b0;
        end
        if (sum_wr && reg_wdata[`FSF_BIT_SUM_DIGITAL]) begin
            next_st.dig_sum = 1'b1;
        end
        if (dig_any) begin
            next_st.dig_sum = 1'b0;
        end

        // Read answer one cycle after the strobe
        next_st.rd_valid = reg_rd_en;
        next_st.rd_data  = `FSF_IDLE_DATA;
        if (reg_rd_en) begin
            case (reg_addr)
                `FSF_ADDR_SUPPLY: begin
                    next_st.rd_data = sup_if.flags;
                end
                `FSF_ADDR_CLOCK: begin
                    next_st.rd_data = clk_if.flags;
                end
                `FSF_ADDR_DIGITAL: begin
                    next_st.rd_data = dig_view;
                end
                `FSF_ADDR_STATUS: begin
                    next_st.rd_data                       = `FSF_IDLE_DATA;
                    next_st.rd_data[`FSF_BIT_SUM_CLOCK]   = st.clk_sum;
                    next_st.rd_data[`FSF_BIT_SUM_DIGITAL] = st.dig_sum;
                end
                default: begin
                    next_st.rd_data = `FSF_IDLE_DATA;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.sup_meta     <= 16'hFFFF;
            st.sup_sync     <= 16'hFFFF;
            st.clk_meta     <= 3'h7;
            st.clk_sync     <= 3'h7;
            st.dig_meta     <= 4'hF;
            st.dig_sync     <= 4'hF;
            st.bank_primary <= 1'b1;
            st.bank_taken   <= 1'b0;
            st.clk_sum      <= 1'b1;
            st.dig_sum      <= 1'b1;
            st.rd_data      <= `FSF_IDLE_DATA;
            st.rd_valid     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rd_data          = st.rd_data;
    assign reg_rd_valid         = st.rd_valid;
    assign clock_summary_ok     = st.clk_sum;
    assign integrity_summary_ok = st.dig_sum;

endmodule : fsf_bank

`default_nettype wire

// ### hdl/fsf_params.svh
// Offsets, field positions, reset values and fixed patterns of the fault flag bank.
// Assumes inclusion by fsf_bank and fsf_flag_reg by bare name.
//
// Functional notes
// - Supply fault register at 0x03 resets to FFFF; 1 means no fault.
// - Flags drop to 0 on fault, stay 0 until host writes 1.
// - Bits 15,13,11 drop on analog, I/O, core overvoltage.
// - Bits 14,12,10 drop on analog, I/O, core undervoltage.
// - Bits 9,8,7 drop on analog, I/O, core supply oscillation.
// - Bits 6,5 drop on analog, I/O regulator overtemperature warning.
// - Bits 4,3 drop while analog, I/O regulator current limit active.
// - Bits 2,1,0 drop on ground A, ground B, core ground disconnect.
// - Clock fault register at 0x04 resets FC07; bits 15:3 read fixed pattern.
// - Clock bit 2 drops when selected clock frequency leaves its window.
// - Clock bit 1 drops on diagnostic oscillator watchdog fault.
// - Clock bit 0 drops on main clock watchdog fault.
// - Integrity register at 0x05 resets EC00, flags and bank bit high.
// - Bits 15,14,13 drop on configuration section 1,2,3 CRC mismatch.
// - Integrity bits 12 and 9:0 always read zero.
// - Bit 11 drops on memory CRC fault; host resets device if recurring.
// - Read-only bit 10 shows chosen bank: 1 primary, 0 backup.
// - Bank bit never pulls the integrity summary low.
// - Status bit 13 low while any enabled clock flag low; write 1 restores.
// - Status bit 12 low while any enabled integrity flag low; write 1 restores.
`ifndef FSF_PARAMS_SVH
`define FSF_PARAMS_SVH

`define FSF_ADDR_STATUS      8'h01
`define FSF_ADDR_SUPPLY      8'h03
`define FSF_ADDR_CLOCK       8'h04
`define FSF_ADDR_DIGITAL     8'h05

`define FSF_SUPPLY_RST       16'hFFFF
`define FSF_CLOCK_RST        16'hFC07
`define FSF_DIGITAL_RST      16'hEC00

`define FSF_SUPPLY_WMASK     16'hFFFF
`define FSF_CLOCK_WMASK      16'h0007
`define FSF_DIGITAL_WMASK    16'hE800
`define FSF_SUPPLY_FIXED     16'h0000
`define FSF_CLOCK_FIXED      16'hFC00
`define FSF_DIGITAL_FIXED    16'h0000

`define FSF_BIT_BANK         10
`define FSF_BIT_SUM_CLOCK    13
`define FSF_BIT_SUM_DIGITAL  12
`define FSF_DIG_CRC1         15
`define FSF_DIG_CRC2         14
`define FSF_DIG_CRC3         13
`define FSF_DIG_MEM          11
`define FSF_IDLE_DATA        16'h0000

`endif

// ### hdl/fsf_pkg.sv
// Types of the fault flag bank.
// Assumes fsf_params.svh on the include path.
`default_nettype none

package fsf_pkg;

    typedef logic [15:0] fsf_word_t;

    typedef struct packed {
        fsf_word_t flags;
    } fsf_flag_state_t;

    typedef struct packed {
        fsf_word_t   sup_meta;
        fsf_word_t   sup_sync;
        logic [2:0]  clk_meta;
        logic [2:0]  clk_sync;
        logic [3:0]  dig_meta;
        logic [3:0]  dig_sync;
        logic        bank_primary;
        logic        bank_taken;
        logic        clk_sum;
        logic        dig_sum;
        fsf_word_t   rd_data;
        logic        rd_valid;
    } fsf_bank_state_t;

endpackage : fsf_pkg

`default_nettype wire

// ### hdl/fsf_flag_if.sv
// Carrier between the bank and one sticky flag register.
// Assumes both ends run on the same clock.
`default_nettype none

interface fsf_flag_if;
    import fsf_pkg::*;

    fsf_word_t fault_n;
    fsf_word_t clr;
    fsf_word_t flags;

    modport drive (output fault_n, output clr, input flags);
    modport store (input fault_n, input clr, output flags);

endinterface : fsf_flag_if

`default_nettype wire

// ### hdl/fsf_flag_reg.sv
// One 16-bit sticky active-low flag register with write-one restore.
// Assumes synchronised fault levels and a one-cycle clear mask.
`include "fsf_params.svh"
`default_nettype none

module fsf_flag_reg
    import fsf_pkg::*;
#(
    parameter fsf_word_t RST   = 16'hFFFF,
    parameter fsf_word_t WMASK = 16'hFFFF,
    parameter fsf_word_t FIXED = 16'h0000
) (
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // Flag carrier
    fsf_flag_if.store    port
);

    fsf_flag_state_t st;
    fsf_flag_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Restore first, then fault, so a fault wins
    always_comb begin
        next_st       = st;
        next_st.flags = st.flags | (port.clr & WMASK);
        next_st.flags = next_st.flags & (port.fault_n | ~WMASK);
        next_st.flags = (next_st.flags & WMASK) | (FIXED & ~WMASK);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.flags <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign port.flags = st.flags;

endmodule : fsf_flag_reg

`default_nettype wire

// ### bench/fsf_bank_props.sv
// Port checker of the fault flag bank.
// Assumes a bind to fsf_bank and one clock domain.
`default_nettype none

module fsf_bank_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr_en,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_rd_en,
    input wire logic [15:0] reg_rd_data,
    // Monitors and summaries
    input wire logic        ground_a_connected,
    input wire logic        main_clock_watchdog_ok,
    input wire logic        diag_osc_watchdog_ok,
    input wire logic        cfg_section1_crc_ok,
    input wire logic        cfg_section2_crc_ok,
    input wire logic        cfg_section3_crc_ok,
    input wire logic        memory_crc_ok,
    input wire logic [2:0]  clock_fault_en,
    input wire logic [3:0]  digital_fault_en,
    input wire logic        clock_summary_ok,
    input wire logic        integrity_summary_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd3;
    logic rd4;
    logic rd5;
    logic dig_ok;
    assign rd3 = reg_rd_en && reg_addr == 8'h03;
    assign rd4 = reg_rd_en && reg_addr == 8'h04;
    assign rd5 = reg_rd_en && reg_addr == 8'h05;
    assign dig_ok = &{cfg_section1_crc_ok, cfg_section2_crc_ok, cfg_section3_crc_ok, memory_crc_ok};
    ////////////////////////////////////////////////////////////////////////
    chk_clk_fixed: assert property (rd4 |=> reg_rd_data[15:3] == 13'h1F80)
        else $error("clock reserved bits wrong");
    chk_dig_zero: assert property (rd5 |=> reg_rd_data[12] == 1'b0 && reg_rd_data[9:0] == 10'h000)
        else $error("integrity reserved bits wrong");
    chk_gnd_drop: assert property (!ground_a_connected ##3 rd3 |=> !reg_rd_data[2])
        else $error("ground flag did not drop");
    chk_wdog_drop: assert property (!main_clock_watchdog_ok ##3 rd4 |=> !reg_rd_data[0])
        else $error("watchdog flag did not drop");
    chk_mem_drop: assert property (!memory_crc_ok ##3 rd5 |=> !reg_rd_data[11])
        else $error("memory flag did not drop");
    chk_csum_low: assert property (clock_fault_en[1] && !diag_osc_watchdog_ok |-> ##4 !clock_summary_ok)
        else $error("clock summary did not fall");
    chk_csum_hold: assert property (!clock_summary_ok && !(reg_wr_en && reg_addr == 8'h01 && reg_wdata[13])
        |=> !clock_summary_ok)
        else $error("clock summary rose alone");
    chk_bank_quiet: assert property ((dig_ok && $stable(digital_fault_en)) [*4] |=> !$fell(integrity_summary_ok))
        else $error("integrity summary fell without fault");
    cover property (rd5 ##1 !reg_rd_data[10]);
    cover property ($fell(clock_summary_ok));
    cover property ($fell(integrity_summary_ok));
endmodule : fsf_bank_props

bind fsf_bank fsf_bank_props u_fsf_bank_props (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
    .reg_rd_data, .ground_a_connected, .main_clock_watchdog_ok, .diag_osc_watchdog_ok, .cfg_section1_crc_ok,
    .cfg_section2_crc_ok, .cfg_section3_crc_ok, .memory_crc_ok, .clock_fault_en, .digital_fault_en,
    .clock_summary_ok, .integrity_summary_ok);

`default_nettype wire

// ### bench/fsf_host.sv
// Host model issuing register reads and writes.
// Assumes read answers registered on the taken edge, sampled half a cycle later.
`default_nettype none

module fsf_host (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic [7:0]       reg_addr,
    output logic             reg_wr_en,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd_en,
    input  wire logic [15:0] reg_rd_data,
    input  wire logic        reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd_en = 1'b0;
    end
    // Write one word, ones restore flags
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // Read one word, bad marker if no answer
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rd_data : 16'hDEAD;
    endtask : rd
endmodule : fsf_host

`default_nettype wire

// ### bench/fsf_bank_tb.sv
// Self-checking bench of the fault flag bank against a reference model.
// Assumes fsf_pkg, the host model and the checker compiled first.
`default_nettype none

module fsf_bank_tb;
    import fsf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_n;
    logic        otp_sel;
    logic [22:0] mon_ok;
    logic [2:0]  cen;
    logic [3:0]  den;
    logic [7:0]  reg_addr;
    logic        reg_wr_en;
    logic        reg_rd_en;
    fsf_word_t   reg_wdata;
    fsf_word_t   rd_data;
    logic        rd_valid;
    logic        cs_ok;
    logic        ds_ok;
    int          err_total;
    int          checked;
    int          regs[8];
    int          cs_m;
    int          ds_m;
    int          i;

    fsf_host u_fsf_host (.clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));
    fsf_bank u_fsf_bank (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
        .ana_overvolt_ok(mon_ok[15]), .ana_undervolt_ok(mon_ok[14]), .io_overvolt_ok(mon_ok[13]),
        .io_undervolt_ok(mon_ok[12]), .core_overvolt_ok(mon_ok[11]), .core_undervolt_ok(mon_ok[10]),
        .ana_oscillation_ok(mon_ok[9]), .io_oscillation_ok(mon_ok[8]), .core_oscillation_ok(mon_ok[7]),
        .ana_overtemp_ok(mon_ok[6]), .io_overtemp_ok(mon_ok[5]), .ana_current_limit_ok(mon_ok[4]),
        .io_current_limit_ok(mon_ok[3]), .ground_a_connected(mon_ok[2]), .ground_b_connected(mon_ok[1]),
        .core_ground_connected(mon_ok[0]), .clock_freq_ok(mon_ok[18]), .diag_osc_watchdog_ok(mon_ok[17]),
        .main_clock_watchdog_ok(mon_ok[16]), .cfg_section1_crc_ok(mon_ok[22]), .cfg_section2_crc_ok(mon_ok[21]),
        .cfg_section3_crc_ok(mon_ok[20]), .memory_crc_ok(mon_ok[19]), .otp_primary_sel(otp_sel),
        .clock_fault_en(cen), .digital_fault_en(den), .clock_summary_ok(cs_ok), .integrity_summary_ok(ds_ok));

    ////////////////////////////////////////////////////////////////////////
    function automatic int addr_of(int n);
        return n < 16 ? 3 : (n < 19 ? 4 : 5);
    endfunction : addr_of
    function automatic int pos_of(int n);
        return n < 16 ? n : (n < 19 ? n - 16 : (n == 19 ? 11 : n - 7));
    endfunction : pos_of
    function automatic int dm();
        return {den[3:1], 1'b0, den[0], 11'h000};
    endfunction : dm
    function automatic void sums();
        for (int n = 0; n < 23; n++) if (!mon_ok[n]) regs[addr_of(n)] &= ~(1 << pos_of(n));
        if ((regs[4] & cen) != cen) cs_m = 0;
        if ((regs[5] & dm()) != dm()) ds_m = 0;
    endfunction : sums
    task automatic cmp(input fsf_word_t got, input fsf_word_t exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input int a, input int d);
        u_fsf_host.wr(a[7:0], d[15:0]);
        if (a == 1) begin
            if (d[13] && (regs[4] & cen) == cen) cs_m = 1;
            if (d[12] && (regs[5] & dm()) == dm()) ds_m = 1;
        end else if (a >= 3 && a <= 5) regs[a] |= d & (a == 3 ? 16'hFFFF : (a == 4 ? 16'h0007 : 16'hE800));
        sums();
    endtask : wr
    task automatic chk(input int a);
        fsf_word_t d;
        u_fsf_host.rd(a[7:0], d);
        cmp(d, a == 1 ? 16'(cs_m << 13 | ds_m << 12) : (a >= 3 && a <= 5 ? 16'(regs[a]) : 16'h0000));
        @(negedge clk);
        cmp({14'h0000, cs_ok, ds_ok}, {14'h0000, 1'(cs_m), 1'(ds_m)});
    endtask : chk
    task automatic hit(input int n, input bit hold);
        @(negedge clk);
        mon_ok[n] = 1'b0;
        @(negedge clk);
        if (!hold) mon_ok[n] = 1'b1;
        @(negedge clk);
        regs[addr_of(n)] &= ~(1 << pos_of(n));
        sums();
    endtask : hit
    task automatic do_reset(input logic sel);
        @(negedge clk);
        otp_sel = sel;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        regs = '{default: 0, 3: 16'hFFFF, 4: 16'hFC07, 5: sel ? 16'hEC00 : 16'hE800};
        cs_m = 1;
        ds_m = 1;
    endtask : do_reset
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(20000 * 8);
        err_total++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        otp_sel = 1'b1;
        mon_ok = '1;
        cen = 3'h7;
        den = 4'hF;
        err_total = 0;
        checked = 0;
        void'($urandom(32'h5227));
        cen = 3'($urandom) | 3'h2;
        den = 4'($urandom) | 4'h1;
        do_reset(1'b1);
        for (int a = 0; a < 8; a++) chk(a);
        for (int n = 0; n < 23; n++) begin
            hit(n, 1'b0);
            chk(addr_of(n));
            wr(addr_of(n), 0);
            chk(addr_of(n));
            wr(addr_of(n), 1 << pos_of(n));
            chk(addr_of(n));
            wr(1, 16'h3000);
            chk(1);
        end
        hit(17, 1'b1);
        wr(4, 16'h0002);
        chk(4);
        mon_ok[17] = 1'b1;
        repeat (3) @(negedge clk);
        wr(4, 16'hFFFF);
        chk(4);
        wr(1, 16'hFFFF);
        wr(5, 16'hFFFF);
        chk(5);
        do_reset(1'b0);
        chk(5);
        chk(1);
        repeat (12) begin
            i = $urandom_range(22);
            hit(i, 1'b0);
            chk(addr_of(i));
            wr(addr_of(i), $urandom);
            chk(addr_of(i));
            wr(1, $urandom);
            chk(1);
        end
        report_and_stop();
    end
endmodule : fsf_bank_tb

`default_nettype wire
